/* File: core/msl_core.sv */
// speed-lock configuration registers, gate policy and lock detection
//
// Contract
// - decode speed control mode at bits 5:4
// - select feedback pulse source at bits 3:2
// - brake bit 0, enable off: coast outputs
// - brake bit 1, enable off: low sides on
// - restart bit 0: latch off after fault
// - restart bit 1: retry automatically after fault
// - lock needs minimum qualifying Hall periods afterwards
// - lock only within maximum period, 2.56 ms steps
// - basic bit forces three-Hall 120 degree drive
// - speed tolerance 1/512 to 1/4 period
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module msl_core
  import msl_pkg::*;
#(
  parameter int STEP_CYCLES  = HALL_STEP_CYCLES,
  parameter int RETRY_CYCLES = RETRY_WAIT_CYCLES,
  parameter int PER_W        = PERIOD_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic [2:0]  hall_i,
  input  wire logic        fb_amp_i,
  input  wire logic        tachometer_input_i,
  input  wire logic        enable_i,
  input  wire logic        fault_i,
  output logic      [2:0]  gate_hi_o,
  output logic      [2:0]  gate_lo_o,
  output logic             gate_oe_o,
  output logic             speed_feedback_pulse_o,
  output logic             pwm_from_clock_o,
  output logic             pwm_from_reg_o,
  output logic             advance_bypass_o,
  output logic             lock_o,
  output logic             irq_o
);
  localparam int RCW = $clog2(RETRY_CYCLES + 1);

  generate
    if (STEP_CYCLES < 1 || RETRY_CYCLES < 1 ||
        PER_W < $clog2(255 * STEP_CYCLES + 1)) begin : g_chk
      $error("msl_core: parameters out of range");
    end
  endgenerate

  // register file state
  logic [15:0]       mode_q;
  logic [15:0]       rev_q;
  logic [15:0]       bt_q;
  logic [IRQ_W-1:0]  irq_st;
  logic [IRQ_W-1:0]  irq_mask;
  logic [15:0]       next_mode;
  logic [15:0]       next_rev;
  logic [15:0]       next_bt;
  logic [IRQ_W-1:0]  next_irq_st;
  logic [IRQ_W-1:0]  next_irq_mask;
  logic [31:0]       next_rdata;
  logic              next_wait;
  logic              next_irq;
  logic [15:0]       wd16;
  logic [15:0]       be16;
  logic [IRQ_W-1:0]  events;
  logic              wr_go;
  logic [2:0]        sel;

  // control state
  msl_fault_type     fst;
  msl_fault_type     next_fst;
  logic [RCW-1:0]    rcnt;
  logic [RCW-1:0]    next_rcnt;
  logic [2:0]        next_hi;
  logic [2:0]        next_lo;
  logic              next_oe;
  logic              next_fb;
  logic [5:0]        comm;

  // lock state
  logic [PER_W-1:0]  prev_per;
  logic [PER_W-1:0]  next_prev_per;
  logic              have_prev;
  logic              next_have_prev;
  logic [7:0]        qcnt;
  logic [7:0]        next_qcnt;
  logic              next_lock;
  logic              hall_edge;
  logic [PER_W-1:0]  meas_per;
  logic [PER_W-1:0]  meas_run;
  logic [PER_W-1:0]  max_lim;
  logic [PER_W-1:0]  per_diff;
  logic [PER_W-1:0]  tol_lim;
  logic              per_ok;
  logic              diff_ok;

  wire logic             brake   = mode_q[MODE_BRK_BIT];
  wire logic             restart = mode_q[MODE_RETRY_BIT];
  wire logic [1:0]       spd     = mode_q[MODE_SPD_LSB +: 2];
  wire logic [1:0]       fbsel   = mode_q[MODE_FB_LSB +: 2];
  wire logic [7:0]       min_per = rev_q[REV_MIN_LSB +: 8];
  wire logic [7:0]       max_per = rev_q[REV_MAX_LSB +: 8];
  wire logic [2:0]       tol     = bt_q[BT_TOL_LSB +: 3];

  msl_hall_meas #(.PER_W(PER_W)) u_meas (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .hall_u_i  (hall_i[0]),
    .edge_o    (hall_edge),
    .period_o  (meas_per),
    .running_o (meas_run)
  );

  // six-step table, phases ordered {w,v,u}, result {hi,lo}
  function automatic logic [5:0] comm120(input logic [2:0] h);
    case (h)
      3'b001:  comm120 = {3'b001, 3'b010};
      3'b011:  comm120 = {3'b001, 3'b100};
      3'b010:  comm120 = {3'b010, 3'b100};
      3'b110:  comm120 = {3'b010, 3'b001};
      3'b100:  comm120 = {3'b100, 3'b001};
      3'b101:  comm120 = {3'b100, 3'b010};
      default: comm120 = 6'h00;
    endcase
  endfunction

  // register bus: one wait state, then the access completes
  assign sel   = address_i[4:2];
  assign wr_go = write_i && !waitrequest_o;
  assign wd16  = writedata_i[15:0];
  assign be16  = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  always_comb begin
    next_wait     = !((read_i || write_i) && waitrequest_o);
    next_mode     = mode_q;
    next_rev      = rev_q;
    next_bt       = bt_q;
    next_irq_mask = irq_mask;
    next_irq_st   = irq_st;
    next_rdata    = readdata_o;
    if (wr_go) begin
      case (sel)
        IDX_MODE: next_mode = (mode_q & ~(be16 & MODE_WMASK)) |
                              (wd16 & be16 & MODE_WMASK);
        IDX_REV:  next_rev = (rev_q & ~be16) | (wd16 & be16);
        IDX_BT:   next_bt = (bt_q & ~(be16 & BT_WMASK)) |
                            (wd16 & be16 & BT_WMASK);
        IDX_IRQ_MASK: if (byteenable_i[0]) next_irq_mask = wd16[IRQ_W-1:0];
        IDX_IRQ_ST: if (byteenable_i[0])
          next_irq_st = irq_st & ~wd16[IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over a simultaneous clear
    next_irq_st = next_irq_st | events;
    if (read_i && waitrequest_o) begin
      case (sel)
        IDX_MODE:     next_rdata = {16'h0000, mode_q};
        IDX_REV:      next_rdata = {16'h0000, rev_q};
        IDX_BT:       next_rdata = {16'h0000, bt_q};
        IDX_IRQ_ST:   next_rdata = {29'h0, irq_st};
        IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        IDX_STATE: begin
          next_rdata                   = 32'h0000_0000;
          next_rdata[ST_LOCK_BIT]      = lock_o;
          next_rdata[ST_FAULT_BIT]     = (fst != ST_RUN);
          next_rdata[ST_RSVD_BIT]      = (spd == SPD_RSVD);
          next_rdata[ST_CNT_LSB +: 8]  = qcnt;
        end
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_irq_st & next_irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_q        <= RST_MODE;
      rev_q         <= RST_REV;
      bt_q          <= RST_BT;
      irq_st        <= RST_IRQ;
      irq_mask      <= RST_IRQ;
      readdata_o    <= 32'h0000_0000;
      waitrequest_o <= 1'b1;
      irq_o         <= 1'b0;
    end else begin
      mode_q        <= next_mode;
      rev_q         <= next_rev;
      bt_q          <= next_bt;
      irq_st        <= next_irq_st;
      irq_mask      <= next_irq_mask;
      readdata_o    <= next_rdata;
      waitrequest_o <= next_wait;
      irq_o         <= next_irq;
    end
  end

  // fault policy, gate drive and mode outputs
  assign comm = comm120(hall_i);

  always_comb begin
    next_fst  = fst;
    next_rcnt = rcnt;
    case (fst)
      ST_RUN: if (fault_i) begin
        next_fst  = restart ? ST_RETRY_WAIT : ST_LATCHED;
        next_rcnt = '0;
      end
      // only the outside party lifts the latch, by dropping enable
      ST_LATCHED: if (!enable_i && !fault_i) next_fst = ST_RUN;
      ST_RETRY_WAIT: begin
        if (rcnt < RCW'(RETRY_CYCLES)) next_rcnt = rcnt + RCW'(1);
        else if (!fault_i) next_fst = ST_RUN;
      end
      default: next_fst = ST_LATCHED;
    endcase
    next_hi = 3'h0;
    next_lo = 3'h0;
    next_oe = 1'b0;
    if (fst == ST_RUN && !fault_i) begin
      if (!enable_i) begin
        next_oe = brake;
        next_lo = brake ? 3'h7 : 3'h0;
      end else begin
        next_oe = 1'b1;
        {next_hi, next_lo} = comm;
      end
    end
    case (fbsel)
      FB_HALL_U:   next_fb = hall_i[0];
      FB_HALL_XOR: next_fb = ^hall_i;
      FB_AMP:      next_fb = fb_amp_i;
      default:     next_fb = tachometer_input_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fst                    <= ST_RUN;
      rcnt                   <= '0;
      gate_hi_o              <= 3'h0;
      gate_lo_o              <= 3'h0;
      gate_oe_o              <= 1'b0;
      speed_feedback_pulse_o <= 1'b0;
      pwm_from_clock_o       <= 1'b0;
      pwm_from_reg_o         <= 1'b0;
      advance_bypass_o       <= 1'b0;
    end else begin
      fst                    <= next_fst;
      rcnt                   <= next_rcnt;
      gate_hi_o              <= next_hi;
      gate_lo_o              <= next_lo;
      gate_oe_o              <= next_oe;
      speed_feedback_pulse_o <= next_fb;
      pwm_from_clock_o       <= (spd == SPD_CLK_PWM);
      pwm_from_reg_o         <= (spd == SPD_REG_PWM);
      advance_bypass_o       <= bt_q[BT_BASIC_BIT];
    end
  end

  // lock detection
  assign max_lim  = PER_W'(max_per) * PER_W'(STEP_CYCLES);
  assign per_diff = (meas_per > prev_per) ? meas_per - prev_per
                                          : prev_per - meas_per;
  assign tol_lim  = prev_per >> (TOL_BASE_SHIFT - {1'b0, tol});
  assign per_ok   = meas_per <= max_lim;
  assign diff_ok  = per_diff <= tol_lim;

  always_comb begin
    next_prev_per  = prev_per;
    next_have_prev = have_prev;
    next_qcnt      = qcnt;
    next_lock      = lock_o;
    if (meas_run > max_lim) begin
      next_qcnt = 8'h00;
      next_lock = 1'b0;
    end else if (hall_edge) begin
      next_prev_per  = meas_per;
      next_have_prev = 1'b1;
      if (have_prev && per_ok && diff_ok) begin
        if (qcnt >= min_per) next_lock = 1'b1;
        else next_qcnt = qcnt + 8'h01;
      end else begin
        next_qcnt = 8'h00;
        next_lock = 1'b0;
      end
    end
  end

  assign events = {(fst == ST_RUN) && fault_i,
                   lock_o && !next_lock,
                   !lock_o && next_lock};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_per  <= '0;
      have_prev <= 1'b0;
      qcnt      <= 8'h00;
      lock_o    <= 1'b0;
    end else begin
      prev_per  <= next_prev_per;
      have_prev <= next_have_prev;
      qcnt      <= next_qcnt;
      lock_o    <= next_lock;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_mode_wr(logic [1:0] code);
    wr_go && sel == IDX_MODE && byteenable_i[0] &&
    writedata_i[MODE_SPD_LSB +: 2] == code;
  endsequence
  sequence s_fault_hit;
    fst == ST_RUN && fault_i;
  endsequence

  spd_reg_mode_a: assert property (
    s_mode_wr(2'h2) |-> ##2 pwm_from_reg_o && !pwm_from_clock_o)
    else $error("register pwm mode not selected");
  fb_hall_u_a: assert property (
    fbsel == FB_HALL_U |=> speed_feedback_pulse_o == $past(hall_i[0]))
    else $error("feedback pulse not from hall u");
  coast_off_a: assert property (
    fst == ST_RUN && !fault_i && !enable_i && !brake |=> !gate_oe_o)
    else $error("coast did not release gates");
  brake_low_a: assert property (
    fst == ST_RUN && !fault_i && !enable_i && brake
    |=> gate_oe_o && gate_lo_o == 3'h7 && gate_hi_o == 3'h0)
    else $error("brake did not turn low sides on");
  latch_hold_a: assert property (
    s_fault_hit ##0 !restart |=> fst == ST_LATCHED ##1 !gate_oe_o)
    else $error("fault not latched off");
  latch_stay_a: assert property (
    fst == ST_LATCHED && enable_i |=> fst == ST_LATCHED)
    else $error("latched fault recovered on its own");
  retry_wait_a: assert property (
    s_fault_hit ##0 restart |=> fst == ST_RETRY_WAIT && rcnt == '0)
    else $error("retry not started");
  lock_min_a: assert property (
    !lock_o ##1 lock_o |-> $past(hall_edge) && $past(qcnt) >= $past(min_per))
    else $error("lock set before minimum periods");
  max_period_a: assert property (
    meas_run > max_lim |=> !lock_o && qcnt == 8'h00)
    else $error("lock held past maximum period");
  basic_mode_a: assert property (
    advance_bypass_o == $past(bt_q[BT_BASIC_BIT]))
    else $error("basic mode not reflected");
  tol_drop_a: assert property (
    hall_edge && have_prev && !diff_ok && meas_run <= max_lim
    |=> !lock_o && qcnt == 8'h00)
    else $error("lock kept outside tolerance");
  irq_level_a: assert property (
    |(irq_st & irq_mask) |-> irq_o)
    else $error("interrupt not raised for unmasked status");
endmodule // msl_core

/* File: pkg/msl_pkg.sv */
// shared constants and types for the motor speed-lock configuration block
package msl_pkg;
  // timing
  localparam real CLK_MHZ           = 100.0;
  localparam real HALL_STEP_MS      = 2.56;
  localparam int  HALL_STEP_CYCLES  = int'($ceil(HALL_STEP_MS * 1000.0 * CLK_MHZ));
  localparam real RETRY_MS          = 5.0;
  localparam int  RETRY_WAIT_CYCLES = int'($ceil(RETRY_MS * 1000.0 * CLK_MHZ));
  localparam int  PERIOD_W          = 27;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_MODE     = 3'h0;
  localparam logic [2:0] IDX_REV      = 3'h2;
  localparam logic [2:0] IDX_BT       = 3'h3;
  localparam logic [2:0] IDX_IRQ_ST   = 3'h4;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h5;
  localparam logic [2:0] IDX_STATE    = 3'h6;

  // reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_REV  = 16'h0000;
  localparam logic [15:0] RST_BT   = 16'h0000;
  localparam logic [2:0]  RST_IRQ  = 3'h0;

  // writable bits, others read zero
  localparam logic [15:0] MODE_WMASK = 16'h003f;
  localparam logic [15:0] BT_WMASK   = 16'hf000;

  // field positions
  localparam int MODE_SPD_LSB   = 4;
  localparam int MODE_FB_LSB    = 2;
  localparam int MODE_BRK_BIT   = 1;
  localparam int MODE_RETRY_BIT = 0;
  localparam int REV_MIN_LSB    = 8;
  localparam int REV_MAX_LSB    = 0;
  localparam int BT_BASIC_BIT   = 15;
  localparam int BT_TOL_LSB     = 12;
  localparam int ST_LOCK_BIT    = 15;
  localparam int ST_FAULT_BIT   = 14;
  localparam int ST_RSVD_BIT    = 13;
  localparam int ST_CNT_LSB     = 0;

  // tolerance code 0 is 1/512 of a period, i.e. a shift of nine
  localparam logic [3:0] TOL_BASE_SHIFT = 4'h9;

  // interrupt bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_LOCK_UP   = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_FAULT     = 2;

  typedef enum logic [1:0] {
    SPD_CLK_FREQ = 2'h0,
    SPD_CLK_PWM  = 2'h1,
    SPD_REG_PWM  = 2'h2,
    SPD_RSVD     = 2'h3
  } msl_spd_mode_type;

  typedef enum logic [1:0] {
    FB_HALL_U   = 2'h0,
    FB_HALL_XOR = 2'h1,
    FB_AMP      = 2'h2,
    FB_TACHO    = 2'h3
  } msl_fb_src_type;

  typedef enum {ST_RUN, ST_LATCHED, ST_RETRY_WAIT} msl_fault_type;
endpackage

/* File: core/msl_hall_meas.sv */
// measures the U-phase Hall period in clock cycles
`timescale 1ns/1ps
module msl_hall_meas #(
  parameter int PER_W = 27
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             hall_u_i,
  output logic                  edge_o,
  output logic [PER_W-1:0]      period_o,
  output logic [PER_W-1:0]      running_o
);
  generate
    if (PER_W < 2) begin : g_chk
      $error("msl_hall_meas: PER_W too small");
    end
  endgenerate

  logic             prev_u;
  logic             next_prev_u;
  logic             next_edge;
  logic [PER_W-1:0] next_period;
  logic [PER_W-1:0] next_running;

  always_comb begin
    next_prev_u  = hall_u_i;
    next_edge    = hall_u_i && !prev_u;
    next_period  = period_o;
    next_running = running_o;
    if (next_edge) begin
      next_period  = running_o;
      next_running = '0;
    end else if (running_o != {PER_W{1'b1}}) begin
      // saturate so a stalled rotor never wraps into a short period
      next_running = running_o + PER_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // a pin already high after reset must not count as a rising edge
      prev_u    <= 1'b1;
      edge_o    <= 1'b0;
      period_o  <= '0;
      running_o <= '0;
    end else begin
      prev_u    <= next_prev_u;
      edge_o    <= next_edge;
      period_o  <= next_period;
      running_o <= next_running;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  edge_period_a: assert property (
    edge_o |-> period_o == $past(running_o) && running_o == '0)
    else $error("period not captured at hall edge");
endmodule // msl_hall_meas

/* File: verification/msl_motor_model.sv */
// behavioural Hall sensor set and power stage watch for the speed-lock block
`timescale 1ns/1ps
module msl_motor_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] per_i,
  input  wire logic [7:0] jit_i,
  input  wire logic [2:0] hall_set_i,
  input  wire logic [2:0] gate_hi_i,
  input  wire logic [2:0] gate_lo_i,
  output logic      [2:0] hall_o,
  output logic            shoot_o
);
  int   cnt = 0;
  int   len = 0;
  logic odd = 1'b0;
  initial hall_o = 3'h0;
  initial shoot_o = 1'b0;
  // period zero parks the rotor on a fixed Hall code
  always @(posedge clk_i) begin
    len = per_i + (odd ? jit_i : 8'h00);
    if (per_i == 8'h00) begin
      cnt <= 0;
      hall_o <= hall_set_i;
    end else begin
      hall_o[0] <= cnt < len / 2;
      hall_o[1] <= ((cnt + len / 3) % len) < len / 2;
      hall_o[2] <= ((cnt + 2 * len / 3) % len) < len / 2;
      if (cnt >= len - 1) begin
        cnt <= 0;
        odd <= !odd;
      end else begin
        cnt <= cnt + 1;
      end
    end
    // a phase with both transistors on would short the supply
    if ((gate_hi_i & gate_lo_i) != 3'h0) begin
      shoot_o <= 1'b1;
    end
  end
endmodule // msl_motor_model

/* File: verification/tb.sv */
// self-checking bench for the speed-lock configuration block
`timescale 1ns/1ps
module tb;
  import msl_pkg::*;
  localparam int STEP  = 16;
  localparam int RETRY = 8;
  typedef struct packed {
    logic [5:0] mode;
    logic [2:0] hall;
    logic       amp;
    logic       tch;
    logic       fb;
    logic       pc;
    logic       pr;
    logic       rsv;
    logic [2:0] hi;
    logic [2:0] lo;
  } msl_row_type;
  localparam msl_row_type ROWS [6] = '{
    '{6'h00, 3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 3'h2},
    '{6'h14, 3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1, 3'h4},
    '{6'h28, 3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{6'h3c, 3'h6, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 3'h1},
    '{6'h04, 3'h4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4, 3'h1},
    '{6'h0c, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h4, 3'h2}};
  logic        clk_i       = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [4:0]  address_i   = 5'h00;
  logic        read_i      = 1'b0;
  logic        write_i     = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic        fb_amp_i    = 1'b0;
  logic        tacho_i     = 1'b0;
  logic        enable_i    = 1'b0;
  logic        fault_i     = 1'b0;
  logic [2:0]  hall_set    = 3'h0;
  logic [7:0]  per         = 8'h00;
  logic [7:0]  jit         = 8'h04;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic [2:0]  hall_i, gate_hi_o, gate_lo_o;
  logic        gate_oe_o, fbp, pwm_c, pwm_r, adv, lock_o, irq_o, shoot;
  logic        hu_q = 1'b0;
  logic [15:0] q;
  int          edges = 0;
  int          n2, n5, nx;
  int          n_fail = 0;
  int          n_checks = 0;

  always #5 clk_i = ~clk_i;

  msl_core #(.STEP_CYCLES(STEP), .RETRY_CYCLES(RETRY)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(4'h3), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .hall_i(hall_i), .fb_amp_i(fb_amp_i),
    .tachometer_input_i(tacho_i), .enable_i(enable_i), .fault_i(fault_i),
    .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o), .gate_oe_o(gate_oe_o),
    .speed_feedback_pulse_o(fbp), .pwm_from_clock_o(pwm_c),
    .pwm_from_reg_o(pwm_r), .advance_bypass_o(adv), .lock_o(lock_o),
    .irq_o(irq_o));

  msl_motor_model motor (
    .clk_i(clk_i), .per_i(per), .jit_i(jit), .hall_set_i(hall_set),
    .gate_hi_i(gate_hi_o), .gate_lo_i(gate_lo_o), .hall_o(hall_i),
    .shoot_o(shoot));

  // rising U edges seen at the pins, for counting periods up to lock
  always @(posedge clk_i) begin
    if (hall_i[0] && !hu_q) edges++;
    hu_q <= hall_i[0];
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] idx,
                     input logic [15:0] d);
    @(posedge clk_i);
    address_i   <= {idx, 2'b00};
    writedata_i <= {16'h0000, d};
    write_i     <= wr;
    read_i      <= !wr;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do @(posedge clk_i);
    while (waitrequest_o !== 1'b0);
    q = readdata_o[15:0];
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    chk("readdata", {16'h0, q}, {16'h0, e});
  endtask

  task automatic fault_pulse;
    fault_i <= 1'b1;
    cyc(1);
    fault_i <= 1'b0;
  endtask

  // parks the rotor so any lock clears, then spins and counts edges
  task automatic run_lock(input logic [15:0] rev, bt, output int n);
    per <= 8'h00;
    cyc(100);
    bus(1'b1, IDX_REV, rev);
    bus(1'b1, IDX_BT, bt);
    edges = 0;
    per <= 8'd40;
    for (int i = 0; i < 600 && lock_o !== 1'b1; i++) cyc(1);
    n = (lock_o === 1'b1) ? edges : -1;
  endtask

  initial begin
    cyc(20000);
    n_fail++;
    end_sim();
  end

  initial begin
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("waitrequest", waitrequest_o, 1'b1);
    chk("lock", lock_o, 1'b0);
    rdc(IDX_MODE, RST_MODE);
    rdc(IDX_REV, RST_REV);
    bus(1'b1, 3'h1, 16'hffff);
    rdc(3'h1, 16'h0000);
    bus(1'b1, IDX_STATE, 16'hffff);
    rdc(IDX_STATE, 16'h0000);
    bus(1'b1, IDX_BT, 16'hffff);
    rdc(IDX_BT, 16'hf000);
    cyc(2);
    chk("advance bypass", adv, 1'b1);
    enable_i <= 1'b1;
    foreach (ROWS[i]) begin
      hall_set <= ROWS[i].hall;
      fb_amp_i <= ROWS[i].amp;
      tacho_i  <= ROWS[i].tch;
      bus(1'b1, IDX_MODE, {10'h0, ROWS[i].mode});
      cyc(3);
      chk("feedback", fbp, ROWS[i].fb);
      chk("pwm clock", pwm_c, ROWS[i].pc);
      chk("pwm reg", pwm_r, ROWS[i].pr);
      chk("gate hi", gate_hi_o, ROWS[i].hi);
      chk("gate lo", gate_lo_o, ROWS[i].lo);
      rdc(IDX_STATE, {2'b00, ROWS[i].rsv, 13'h0});
      rdc(IDX_MODE, {10'h0, ROWS[i].mode});
    end
    enable_i <= 1'b0;
    bus(1'b1, IDX_MODE, 16'h0000);
    cyc(3);
    chk("coast oe", gate_oe_o, 1'b0);
    bus(1'b1, IDX_MODE, 16'h0002);
    cyc(3);
    chk("brake oe", gate_oe_o, 1'b1);
    chk("brake lo", gate_lo_o, 3'h7);
    chk("brake hi", gate_hi_o, 3'h0);
    bus(1'b1, IDX_MODE, 16'h0000);
    bus(1'b1, IDX_IRQ_MASK, 16'h0004);
    enable_i <= 1'b1;
    fault_pulse();
    cyc(20);
    chk("latched oe", gate_oe_o, 1'b0);
    chk("fault irq", irq_o, 1'b1);
    rdc(IDX_STATE, 16'h4000);
    bus(1'b1, IDX_IRQ_ST, 16'h0004);
    cyc(2);
    chk("irq cleared", irq_o, 1'b0);
    enable_i <= 1'b0;
    cyc(3);
    enable_i <= 1'b1;
    cyc(3);
    chk("unlatched oe", gate_oe_o, 1'b1);
    bus(1'b1, IDX_MODE, 16'h0001);
    fault_pulse();
    cyc(4);
    chk("retry oe off", gate_oe_o, 1'b0);
    cyc(RETRY + 8);
    chk("retry oe on", gate_oe_o, 1'b1);
    bus(1'b1, IDX_MODE, 16'h0000);
    bus(1'b1, IDX_IRQ_ST, 16'h0007);
    bus(1'b1, IDX_IRQ_MASK, 16'h0003);
    run_lock(16'h0204, 16'h7000, n2);
    run_lock(16'h0504, 16'h7000, n5);
    chk("lock reached", n2 > 0, 1'b1);
    chk("extra periods", n5 - n2, 3);
    per <= 8'h00;
    cyc(90);
    chk("lock dropped", lock_o, 1'b0);
    run_lock(16'h0204, 16'h0000, nx);
    chk("tight tolerance", nx, -1);
    run_lock(16'h0202, 16'h7000, nx);
    chk("period over max", nx, -1);
    rdc(IDX_IRQ_ST, 16'h0003);
    chk("lock irq", irq_o, 1'b1);
    bus(1'b1, IDX_IRQ_MASK, 16'h0000);
    cyc(2);
    chk("masked irq", irq_o, 1'b0);
    bus(1'b1, IDX_IRQ_ST, 16'h0003);
    rdc(IDX_IRQ_ST, 16'h0000);
    // mid-run reset with live settings and gates driven
    bus(1'b1, IDX_MODE, 16'h0023);
    bus(1'b1, IDX_IRQ_MASK, 16'h0007);
    cyc(3);
    chk("pwm reg before reset", pwm_r, 1'b1);
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("reset waitrequest", waitrequest_o, 1'b1);
    chk("reset pwm reg", pwm_r, 1'b0);
    chk("reset oe", gate_oe_o, 1'b0);
    chk("reset lock", lock_o, 1'b0);
    rdc(IDX_MODE, RST_MODE);
    rdc(IDX_IRQ_MASK, 16'h0000);
    chk("shoot through", shoot, 1'b0);
    end_sim();
  end
endmodule // tb
